// ==== verification/ias_plant.sv ====
`timescale 1ns/10ps
`default_nettype none

// ****************************************************
// Plant contacts: each acknowledge follows its command a cycle later.
// ****************************************************
module ias_plant (
    input wire logic clk_i, // System clock.
    input wire logic [10:0] ack_cmd_i, // Wanted contact states.
    output logic [10:0] digital_input_o // Contact levels at the pins.
);
    initial digital_input_o = 11'h005;
    always @(posedge clk_i) begin
        digital_input_o <= ack_cmd_i;
    end
endmodule : ias_plant

`default_nettype wire

// ==== verification/ias_props.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ias_defines.svh"

module ias_props #(
    parameter int TICK_CYCLES = 4,
    parameter int TIMEOUT_TICKS = 5
) (
    input wire logic clk_i, // System clock.
    input wire logic rst_i, // Synchronous reset.
    input wire logic wb_cyc_i, // Bus cycle.
    input wire logic wb_stb_i, // Bus strobe.
    input wire logic wb_we_i, // Write enable.
    input wire logic [7:0] wb_adr_i, // Byte address.
    input wire logic wb_ack_o, // Acknowledge.
    input wire logic [15:0] alarm_word_one_o, // Alarm word one.
    input wire logic [15:0] fault_word_two_o, // Fault word two.
    input wire logic start_inhibit_o, // Start block.
    input wire logic coast_o, // Coast request.
    input wire logic trip_o, // Fault latched.
    input wire logic [15:0] used_control_word_i // Used control word.
);
    // ************************************************
    // Length of the current overtemp alarm run.
    // ************************************************
    int unsigned hot_ff;
    logic clr_wr;
    assign clr_wr = wb_ack_o && wb_we_i && wb_adr_i == `IAS_OFS_FAULT;

    always_ff @(posedge clk_i) begin
        if (rst_i || !alarm_word_one_o[`IAS_ALM_OVERTEMP_BIT]) begin
            hot_ff <= 0;
        end else begin
            hot_ff <= hot_ff + 1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus request not acknowledged");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge longer than one cycle");
    property p_inhibit;
        start_inhibit_o == alarm_word_one_o[`IAS_ALM_DYN_BIT];
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("start block differs from braking alarm");
    property p_coast;
        coast_o == alarm_word_one_o[`IAS_ALM_DCB_BIT];
    endproperty
    a_coast: assert property (p_coast)
        else $error("coast differs from breaker alarm");
    property p_trip;
        trip_o == (fault_word_two_o != 16'h0000);
    endproperty
    a_trip: assert property (p_trip)
        else $error("trip differs from fault word");
    property p_spare;
        (alarm_word_one_o & 16'hFFE3) == 16'h0000
            && (fault_word_two_o & 16'hFB7F) == 16'h0000;
    endproperty
    a_spare: assert property (p_spare)
        else $error("unused alarm or fault bit set");
    property p_fan_hold;
        fault_word_two_o[`IAS_FLT_FAN_BIT] && !clr_wr
            |=> fault_word_two_o[`IAS_FLT_FAN_BIT];
    endproperty
    a_fan_hold: assert property (p_fan_hold)
        else $error("fan fault dropped without clear");
    property p_cont_hold;
        fault_word_two_o[`IAS_FLT_CONT_BIT] && !clr_wr
            |=> fault_word_two_o[`IAS_FLT_CONT_BIT];
    endproperty
    a_cont_hold: assert property (p_cont_hold)
        else $error("contactor fault dropped without clear");
    property p_timeout;
        $rose(fault_word_two_o[`IAS_FLT_FAN_BIT])
            |-> hot_ff >= (TIMEOUT_TICKS - 2) * TICK_CYCLES;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("fan fault before timeout");
    property p_dyn_on;
        $rose(alarm_word_one_o[`IAS_ALM_DYN_BIT])
            |-> $past(used_control_word_i[`IAS_ON_CMD_BIT])
            && !$past(used_control_word_i[`IAS_ON_CMD_BIT], 2);
    endproperty
    a_dyn_on: assert property (p_dyn_on)
        else $error("braking alarm set without a new On command");
endmodule : ias_props

`default_nettype wire

// ==== verification/ias_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ias_defines.svh"

module ias_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [10:0] ack_cmd = 11'h005;
    logic [15:0] used_control_word_i = 16'h0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [10:0] digital_input_i;
    logic [15:0] speed_ref_o, alarm_word_one_o, fault_word_two_o;
    logic [1:0] jog_active_o;
    logic start_inhibit_o, coast_o, trip_o, irq_o;
    int n_mismatch = 0;
    int num_checks = 0;

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    ias_plant i_plant (.clk_i(clk_i), .ack_cmd_i(ack_cmd),
        .digital_input_o(digital_input_i));
    ias_top #(.TICK_CYCLES(4), .TIMEOUT_TICKS(5)) i_dut (.clk_i, .rst_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .digital_input_i, .used_control_word_i,
        .speed_ref_o, .jog_active_o, .alarm_word_one_o, .fault_word_two_o,
        .start_inhibit_o, .coast_o, .trip_o, .irq_o);

    // ************************************************
    // Shared tasks.
    // ************************************************
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_sel_i <= 4'hF;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: no bus answer", $time);
            print_verdict();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q, exp);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    task automatic wait_flt(input logic [15:0] exp);
        int n;
        n = 0;
        while (fault_word_two_o !== exp && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(fault_word_two_o), 32'(exp));
        if (fault_word_two_o !== exp) begin
            print_verdict();
        end
    endtask : wait_flt

    // ************************************************
    // Scenarios.
    // ************************************************
    task automatic t_reset;
        rd(`IAS_OFS_ACK_SEL, 32'h0000_0301);
        rd(`IAS_OFS_INVERT, 32'h0000_0000);
        rd(`IAS_OFS_JOG_SEL, 32'h0000_0000);
        rd(`IAS_OFS_IRQ_STAT, 32'h0000_0000);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000);
        wr(`IAS_OFS_IRQ_MASK, 32'h0000_001F);
        chk(32'(alarm_word_one_o), 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_jog;
        wr(`IAS_OFS_FIXED_SPEED, 32'h2222_1111);
        wr(`IAS_OFS_JOG_SEL, 32'h0000_0605);
        ack_cmd <= 11'h015;
        cyc(6);
        chk(32'(speed_ref_o), 32'h0000_1111);
        chk(32'(jog_active_o), 32'h0000_0001);
        ack_cmd <= 11'h035;
        cyc(6);
        chk(32'(speed_ref_o), 32'h0000_1111);
        ack_cmd <= 11'h025;
        cyc(6);
        chk(32'(speed_ref_o), 32'h0000_2222);
        chk(32'(jog_active_o), 32'h0000_0002);
        ack_cmd <= 11'h005;
        cyc(6);
        chk(32'(speed_ref_o), 32'h0000_0000);
        $display("test jog done");
    endtask : t_jog

    task automatic t_fan;
        ack_cmd <= 11'h004;
        cyc(6);
        chk(32'(alarm_word_one_o), 32'h0000_0008);
        chk(32'(irq_o), 32'h0000_0001);
        ack_cmd <= 11'h005;
        cyc(6);
        chk(32'(alarm_word_one_o), 32'h0000_0000);
        ack_cmd <= 11'h004;
        cyc(13);
        ack_cmd <= 11'h005;
        cyc(1);
        ack_cmd <= 11'h004;
        cyc(13);
        chk(32'(fault_word_two_o), 32'h0000_0000);
        wait_flt(16'h0400);
        chk(32'(trip_o), 32'h0000_0001);
        rd(`IAS_OFS_IRQ_STAT, 32'h0000_0005);
        ack_cmd <= 11'h005;
        cyc(4);
        wr(`IAS_OFS_FAULT, 32'h0000_0400);
        wr(`IAS_OFS_IRQ_MASK, 32'h0000_0000);
        cyc(1);
        chk(32'(irq_o), 32'h0000_0000);
        wr(`IAS_OFS_IRQ_MASK, 32'h0000_001F);
        cyc(1);
        chk(32'(irq_o), 32'h0000_0001);
        wr(`IAS_OFS_IRQ_STAT, 32'h0000_001F);
        cyc(1);
        chk(32'(irq_o), 32'h0000_0000);
        chk(32'(fault_word_two_o), 32'h0000_0000);
        $display("test fan done");
    endtask : t_fan

    task automatic t_cont;
        wr(`IAS_OFS_ACK_SEL, 32'h0000_0001);
        ack_cmd <= 11'h001;
        cyc(40);
        chk(32'(fault_word_two_o), 32'h0000_0000);
        wr(`IAS_OFS_ACK_SEL, 32'h0000_0301);
        wait_flt(16'h0080);
        ack_cmd <= 11'h005;
        cyc(4);
        wr(`IAS_OFS_FAULT, 32'h0000_0080);
        cyc(1);
        chk(32'(fault_word_two_o), 32'h0000_0000);
        wr(`IAS_OFS_IRQ_STAT, 32'h0000_001F);
        $display("test contactor done");
    endtask : t_cont

    task automatic t_dyn;
        wr(`IAS_OFS_ACK_SEL, 32'h0004_0301);
        ack_cmd <= 11'h00D;
        cyc(6);
        used_control_word_i <= 16'h0008;
        cyc(4);
        chk(32'(alarm_word_one_o), 32'h0000_0010);
        chk(32'(start_inhibit_o), 32'h0000_0001);
        ack_cmd <= 11'h005;
        cyc(6);
        chk(32'(start_inhibit_o), 32'h0000_0000);
        used_control_word_i <= 16'h0000;
        cyc(2);
        used_control_word_i <= 16'h0008;
        cyc(4);
        chk(32'(alarm_word_one_o), 32'h0000_0000);
        used_control_word_i <= 16'h0000;
        $display("test braking done");
    endtask : t_dyn

    task automatic t_dcb;
        wr(`IAS_OFS_ACK_SEL, 32'h0704_0301);
        cyc(5);
        chk(32'(alarm_word_one_o), 32'h0000_0004);
        chk(32'(coast_o), 32'h0000_0001);
        wr(`IAS_OFS_INVERT, 32'h0000_0040);
        cyc(5);
        chk(32'(coast_o), 32'h0000_0000);
        rd(`IAS_OFS_INPUTS, 32'h0000_0045);
        $display("test breaker done");
    endtask : t_dcb

    initial begin
        cyc(5);
        rst_i <= 1'b0;
        t_reset();
        t_jog();
        t_fan();
        t_cont();
        t_dyn();
        t_dcb();
        print_verdict();
    end
endmodule : ias_tb_top

bind ias_top ias_props #(.TICK_CYCLES(TICK_CYCLES),
    .TIMEOUT_TICKS(TIMEOUT_TICKS)) i_props (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .alarm_word_one_o,
    .fault_word_two_o, .start_inhibit_o, .coast_o, .trip_o,
    .used_control_word_i);

`default_nettype wire

// ==== verilog/ias_defines.svh ====
`ifndef IAS_DEFINES_SVH
`define IAS_DEFINES_SVH

// ****************************************************
// Register offsets (byte addresses).
// ****************************************************
`define IAS_OFS_JOG_SEL 8'h00
`define IAS_OFS_ACK_SEL 8'h04
`define IAS_OFS_INVERT 8'h08
`define IAS_OFS_FIXED_SPEED 8'h0C
`define IAS_OFS_ALARM 8'h10
`define IAS_OFS_FAULT 8'h14
`define IAS_OFS_IRQ_STAT 8'h18
`define IAS_OFS_IRQ_MASK 8'h1C
`define IAS_OFS_INPUTS 8'h20

// ****************************************************
// Field positions.
// ****************************************************
`define IAS_JOG_ONE_LSB 0
`define IAS_JOG_TWO_LSB 8
`define IAS_FAN_SEL_LSB 0
`define IAS_CONT_SEL_LSB 8
`define IAS_DYN_SEL_LSB 16
`define IAS_DCB_SEL_LSB 24
`define IAS_SPEED_TWO_LSB 16
`define IAS_ALM_DCB_BIT 2
`define IAS_ALM_OVERTEMP_BIT 3
`define IAS_ALM_DYN_BIT 4
`define IAS_FLT_CONT_BIT 7
`define IAS_FLT_FAN_BIT 10
`define IAS_ON_CMD_BIT 3
`define IAS_IRQ_FAN_FLT 0
`define IAS_IRQ_CONT_FLT 1
`define IAS_IRQ_OVERTEMP 2
`define IAS_IRQ_DYN 3
`define IAS_IRQ_DCB 4

// ****************************************************
// Selector codes and reset values.
// ****************************************************
`define IAS_SEL_NOT_USED 4'h0
`define IAS_SEL_LAST_DI 4'hB
`define IAS_RST_FAN_SEL 4'h1
`define IAS_RST_CONT_SEL 4'h3
`define IAS_RST_INVERT 7'h00
`define IAS_RST_SPEED 16'h0000

// ****************************************************
// Timing.
// ****************************************************
`define IAS_CLK_NS 25
`define IAS_TICK_NS 1000000
`define IAS_TICK_CYC ((`IAS_TICK_NS + `IAS_CLK_NS - 1) / `IAS_CLK_NS)
`define IAS_TIMEOUT_S 10
`define IAS_TICKS_PER_S 1000
`define IAS_TIMEOUT_TICKS (`IAS_TIMEOUT_S * `IAS_TICKS_PER_S)
`define IAS_TICK_W 16
`define IAS_TMR_W 14

`endif

// ==== verilog/ias_pkg.sv ====
`include "ias_defines.svh"

package ias_pkg;

    // ************************************************
    // Complete register state of the supervisor.
    // ************************************************
    typedef struct packed {
        logic wb_ack;
        logic [31:0] wb_dat;
        logic [10:0] sync1;
        logic [10:0] sync2;
        logic [4:0] jog_one_sel;
        logic [4:0] jog_two_sel;
        logic [3:0] fan_sel;
        logic [3:0] cont_sel;
        logic [3:0] dyn_sel;
        logic [3:0] dcb_sel;
        logic [6:0] invert;
        logic [15:0] speed_one;
        logic [15:0] speed_two;
        logic [`IAS_TICK_W-1:0] tick_cnt;
        logic tick;
        logic [1:0][`IAS_TMR_W-1:0] tmr;
        logic fan_fault;
        logic cont_fault;
        logic overtemp;
        logic dyn_alarm;
        logic dcb_alarm;
        logic on_prev;
        logic [4:0] irq_stat;
        logic [4:0] irq_mask;
        logic [15:0] speed_ref;
        logic [1:0] jog_act;
        logic [1:0] warm;
    } ias_state_t;

endpackage : ias_pkg

// ==== verilog/ias_top.sv ====
// Summary of operation
// - Jog one active selects fixed speed one.
// - Jog two active without jog one selects fixed speed two.
// - Selector zero disables acknowledge supervision.
// - Fan ack missing 10 s trips fault.
// - Fan ack missing sets overtemp alarm immediately.
// - Fan ack return clears alarm, no fault.
// - Contactor ack missing 10 s trips fault.
// - Braking ack present at On sets alarm.
// - Braking alarm inhibits start while braking.
// - DC breaker ack missing sets alarm.
// - DC breaker alarm makes motor coast.
// - Inputs one to seven individually invertible.
`include "ias_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module ias_top #(
    parameter int TICK_CYCLES = `IAS_TICK_CYC,
    parameter int TIMEOUT_TICKS = `IAS_TIMEOUT_TICKS
) (
    input wire logic clk_i, // System clock, 40 MHz.
    input wire logic rst_i, // Synchronous reset.
    input wire logic wb_cyc_i, // Bus cycle.
    input wire logic wb_stb_i, // Bus strobe.
    input wire logic wb_we_i, // Write enable.
    input wire logic [7:0] wb_adr_i, // Byte address.
    input wire logic [3:0] wb_sel_i, // Byte enables.
    input wire logic [31:0] wb_dat_i, // Write data.
    output logic [31:0] wb_dat_o, // Read data.
    output logic wb_ack_o, // Acknowledge.
    input wire logic [10:0] digital_input_i, // Raw input pins.
    input wire logic [15:0] used_control_word_i, // Used control word.
    output logic [15:0] speed_ref_o, // Jog speed reference.
    output logic [1:0] jog_active_o, // Jog one, jog two active.
    output logic [15:0] alarm_word_one_o, // Alarm word one.
    output logic [15:0] fault_word_two_o, // Fault word two.
    output logic start_inhibit_o, // Blocks drive start.
    output logic coast_o, // Remove torque, coast.
    output logic trip_o, // Any fault latched.
    output logic irq_o // Level interrupt.
);

    // ************************************************
    // State and conditioned inputs.
    // ************************************************
    ias_pkg::ias_state_t st_ff;
    ias_pkg::ias_state_t nxt_st;
    logic [10:0] din;
    logic req;
    logic wr_go;
    logic [31:0] rd_val;
    logic [31:0] wmask;

    // Inputs one to seven pass an inversion stage.
    genvar gi;
    generate
        for (gi = 0; gi < 11; gi++) begin : g_din
            if (gi < 7) begin : g_inv
                assign din[gi] = st_ff.sync2[gi] ^ st_ff.invert[gi];
            end else begin : g_dir
                assign din[gi] = st_ff.sync2[gi];
            end
        end
    endgenerate

    // Returns the state of the input a selector points at.
    function automatic logic pick(input logic [4:0] sel,
                                  input logic [10:0] d);
        logic r;
        r = 1'b0;
        if (sel != 5'h00 && sel <= {1'b0, `IAS_SEL_LAST_DI}) begin
            r = d[4'(sel - 5'h01)];
        end
        return r;
    endfunction : pick

    // Ack missing when the selector is not zero and its input is low; codes above 11 have no input and read as missing.
    function automatic logic missing(input logic [3:0] sel,
                                     input logic [10:0] d);
        logic r;
        r = 1'b0;
        if (sel != `IAS_SEL_NOT_USED) begin
            r = !pick({1'b0, sel}, d);
        end
        return r;
    endfunction : missing

    // ************************************************
    // Bus decode.
    // ************************************************
    assign req = wb_cyc_i && wb_stb_i;
    // A write lands on the edge that also ends the acknowledge.
    assign wr_go = req && st_ff.wb_ack && wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (wb_adr_i)
            `IAS_OFS_JOG_SEL: begin
                rd_val[`IAS_JOG_ONE_LSB +: 5] = st_ff.jog_one_sel;
                rd_val[`IAS_JOG_TWO_LSB +: 5] = st_ff.jog_two_sel;
            end
            `IAS_OFS_ACK_SEL: begin
                rd_val[`IAS_FAN_SEL_LSB +: 4] = st_ff.fan_sel;
                rd_val[`IAS_CONT_SEL_LSB +: 4] = st_ff.cont_sel;
                rd_val[`IAS_DYN_SEL_LSB +: 4] = st_ff.dyn_sel;
                rd_val[`IAS_DCB_SEL_LSB +: 4] = st_ff.dcb_sel;
            end
            `IAS_OFS_INVERT: begin
                rd_val[6:0] = st_ff.invert;
            end
            `IAS_OFS_FIXED_SPEED: begin
                rd_val[15:0] = st_ff.speed_one;
                rd_val[`IAS_SPEED_TWO_LSB +: 16] = st_ff.speed_two;
            end
            `IAS_OFS_ALARM: begin
                rd_val[15:0] = alarm_word_one_o;
            end
            `IAS_OFS_FAULT: begin
                rd_val[15:0] = fault_word_two_o;
            end
            `IAS_OFS_IRQ_STAT: begin
                rd_val[4:0] = st_ff.irq_stat;
            end
            `IAS_OFS_IRQ_MASK: begin
                rd_val[4:0] = st_ff.irq_mask;
            end
            `IAS_OFS_INPUTS: begin
                rd_val[10:0] = din;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // ************************************************
    // Next-state logic.
    // ************************************************
    always_comb begin
        logic [31:0] w;
        logic fan_miss;
        logic cont_miss;
        logic dcb_miss;
        logic dyn_on;
        logic on_rise;
        logic [1:0] miss;
        logic [1:0] expire;
        logic [4:0] ev;
        logic [4:0] clr;
        logic j1;
        logic j2;
        w = 32'h0000_0000;
        fan_miss = st_ff.warm[1] && missing(st_ff.fan_sel, din);
        cont_miss = st_ff.warm[1] && missing(st_ff.cont_sel, din);
        dcb_miss = st_ff.warm[1] && missing(st_ff.dcb_sel, din);
        dyn_on = st_ff.warm[1] && (st_ff.dyn_sel != `IAS_SEL_NOT_USED) &&
                 pick({1'b0, st_ff.dyn_sel}, din);
        on_rise = used_control_word_i[`IAS_ON_CMD_BIT] && !st_ff.on_prev;
        miss = {cont_miss, fan_miss};
        expire = 2'b00;
        ev = 5'h00;
        clr = 5'h00;
        j1 = pick(st_ff.jog_one_sel, din);
        j2 = pick(st_ff.jog_two_sel, din);
        nxt_st = st_ff;

        // ********************************
        // Bus answer one cycle after the request.
        // ********************************
        nxt_st.wb_ack = req && !st_ff.wb_ack;
        if (req && !st_ff.wb_ack) begin
            nxt_st.wb_dat = rd_val;
        end

        // ********************************
        // Pin synchronisers.
        // ********************************
        nxt_st.sync1 = digital_input_i;
        nxt_st.sync2 = st_ff.sync1;
        // Supervision waits until both flops hold real pin levels.
        nxt_st.warm = {st_ff.warm[0], 1'b1};

        // ********************************
        // Register writes.
        // ********************************
        if (wr_go) begin
            unique case (wb_adr_i)
                `IAS_OFS_JOG_SEL: begin
                    w = (rd_val & ~wmask) | (wb_dat_i & wmask);
                    nxt_st.jog_one_sel = w[`IAS_JOG_ONE_LSB +: 5];
                    nxt_st.jog_two_sel = w[`IAS_JOG_TWO_LSB +: 5];
                end
                `IAS_OFS_ACK_SEL: begin
                    w = (rd_val & ~wmask) | (wb_dat_i & wmask);
                    nxt_st.fan_sel = w[`IAS_FAN_SEL_LSB +: 4];
                    nxt_st.cont_sel = w[`IAS_CONT_SEL_LSB +: 4];
                    nxt_st.dyn_sel = w[`IAS_DYN_SEL_LSB +: 4];
                    nxt_st.dcb_sel = w[`IAS_DCB_SEL_LSB +: 4];
                end
                `IAS_OFS_INVERT: begin
                    w = (rd_val & ~wmask) | (wb_dat_i & wmask);
                    nxt_st.invert = w[6:0];
                end
                `IAS_OFS_FIXED_SPEED: begin
                    w = (rd_val & ~wmask) | (wb_dat_i & wmask);
                    nxt_st.speed_one = w[15:0];
                    nxt_st.speed_two = w[`IAS_SPEED_TWO_LSB +: 16];
                end
                `IAS_OFS_FAULT: begin
                    w = wb_dat_i & wmask;
                end
                `IAS_OFS_IRQ_STAT: begin
                    clr = wb_dat_i[4:0] & wmask[4:0];
                end
                `IAS_OFS_IRQ_MASK: begin
                    w = (rd_val & ~wmask) | (wb_dat_i & wmask);
                    nxt_st.irq_mask = w[4:0];
                end
                default: begin
                    w = 32'h0000_0000;
                end
            endcase
        end

        // ********************************
        // Timeout tick from the system clock.
        // ********************************
        nxt_st.tick = 1'b0;
        if (st_ff.tick_cnt == `IAS_TICK_W'(TICK_CYCLES - 1)) begin
            nxt_st.tick_cnt = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.tick_cnt = st_ff.tick_cnt + `IAS_TICK_W'(1);
        end

        // ********************************
        // Fan and contactor timeout counters.
        // ********************************
        // A counter parks at its limit while the acknowledge stays away.
        for (int i = 0; i < 2; i++) begin
            if (!miss[i]) begin
                nxt_st.tmr[i] = '0;
            end else if (st_ff.tmr[i] == `IAS_TMR_W'(TIMEOUT_TICKS)) begin
                expire[i] = 1'b1;
            end else if (st_ff.tick) begin
                nxt_st.tmr[i] = st_ff.tmr[i] + `IAS_TMR_W'(1);
            end
        end

        // ********************************
        // Faults latch; a new trip wins over the clear.
        // ********************************
        nxt_st.fan_fault = (st_ff.fan_fault &&
            !w[`IAS_FLT_FAN_BIT]) || expire[0];
        nxt_st.cont_fault = (st_ff.cont_fault &&
            !w[`IAS_FLT_CONT_BIT]) || expire[1];
        if (wb_adr_i != `IAS_OFS_FAULT) begin
            nxt_st.fan_fault = st_ff.fan_fault || expire[0];
            nxt_st.cont_fault = st_ff.cont_fault || expire[1];
        end

        // ********************************
        // Alarms.
        // ********************************
        nxt_st.overtemp = fan_miss;
        nxt_st.dcb_alarm = dcb_miss;
        nxt_st.on_prev = used_control_word_i[`IAS_ON_CMD_BIT];
        // The braking alarm clears once its acknowledge goes away.
        if (!dyn_on) begin
            nxt_st.dyn_alarm = 1'b0;
        end else if (on_rise) begin
            nxt_st.dyn_alarm = 1'b1;
        end

        // ********************************
        // Interrupt events, set wins over clear.
        // ********************************
        ev[`IAS_IRQ_FAN_FLT] = expire[0] && !st_ff.fan_fault;
        ev[`IAS_IRQ_CONT_FLT] = expire[1] && !st_ff.cont_fault;
        ev[`IAS_IRQ_OVERTEMP] = fan_miss && !st_ff.overtemp;
        ev[`IAS_IRQ_DYN] = nxt_st.dyn_alarm && !st_ff.dyn_alarm;
        ev[`IAS_IRQ_DCB] = dcb_miss && !st_ff.dcb_alarm;
        nxt_st.irq_stat = (st_ff.irq_stat & ~clr) | ev;

        // ********************************
        // Jog speed selection, jog one first.
        // ********************************
        nxt_st.jog_act = {j2 && !j1, j1};
        if (j1) begin
            nxt_st.speed_ref = st_ff.speed_one;
        end else if (j2) begin
            nxt_st.speed_ref = st_ff.speed_two;
        end else begin
            // With no jog active the reference rests at zero.
            nxt_st.speed_ref = `IAS_RST_SPEED;
        end
    end

    // ************************************************
    // State register.
    // ************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            // Fan and contactor selectors leave reset pointing at their usual inputs.
            st_ff.fan_sel <= `IAS_RST_FAN_SEL;
            st_ff.cont_sel <= `IAS_RST_CONT_SEL;
            st_ff.invert <= `IAS_RST_INVERT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************
    // Outputs.
    // ************************************************
    // Spare bits of both words stay low.
    always_comb begin
        alarm_word_one_o = 16'h0000;
        alarm_word_one_o[`IAS_ALM_DCB_BIT] = st_ff.dcb_alarm;
        alarm_word_one_o[`IAS_ALM_OVERTEMP_BIT] = st_ff.overtemp;
        alarm_word_one_o[`IAS_ALM_DYN_BIT] = st_ff.dyn_alarm;
        fault_word_two_o = 16'h0000;
        fault_word_two_o[`IAS_FLT_CONT_BIT] = st_ff.cont_fault;
        fault_word_two_o[`IAS_FLT_FAN_BIT] = st_ff.fan_fault;
    end

    assign wb_dat_o = st_ff.wb_dat;
    assign wb_ack_o = st_ff.wb_ack;
    assign speed_ref_o = st_ff.speed_ref;
    assign jog_active_o = st_ff.jog_act;
    assign start_inhibit_o = st_ff.dyn_alarm;
    assign coast_o = st_ff.dcb_alarm;
    assign trip_o = st_ff.fan_fault || st_ff.cont_fault;
    // The interrupt is a level; it drops when software clears or masks it.
    assign irq_o = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule : ias_top

`default_nettype wire
